// ==== rsc_ctl.sv ====
// Purpose: dram refresh scheduler and sync-rom clock pin 0 control
// Assumes: sleep, refresh engine and static engine signals are on hclk
// Notes: ahb-lite slave, reads take one wait state, writes none
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module rsc_ctl import rsc_pkg::*; (
  // clock, reset, clock enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // power management
  input wire logic sleep_enter,
  input wire logic sleep_reset,
  input wire logic boot_bank_sync_rom_select,
  // memory engines
  input wire rsc_sbus_t sbus,
  input wire logic dram_burst,
  input wire logic pccard_busy,
  input wire logic refresh_done,
  // refresh control
  output logic refresh_all_banks,
  output logic static_hold,
  output logic dram_hold,
  // sync rom pins and commands
  output logic rom_clock_pin0,
  output logic rom_clock_full_en,
  output logic rom_clock_enable_pin0,
  output rsc_romcmd_t rom_cmd,
  output logic rom_auto_mrs_read_ok,
  output logic rom_auto_any_ok
);
  logic strap_s;
  logic [1:0] init_cnt_r;
  logic init_done_r;
  logic strap_load;
  logic cke_r;
  logic run_r;
  logic div_r;
  logic sw_cke_off_r;
  logic [RSC_RI_W-1:0] ri_r;
  logic rd_pend_r;
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic ctrl_wr;
  logic rfsh_wr;
  logic new_cke;
  logic [31:0] rd_val;
  rsc_rf_state_t rf_st_r;
  rsc_rf_state_t rf_nxt;
  logic [1:0] rd_cnt_r;
  logic expire;
  logic restart;
  logic ins_ok;

  // strap is a pin, so it is synchronised before use
  rsc_sync3 u_strap (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .pin_in(boot_bank_sync_rom_select),
    .level_out(strap_s)
  );

  rsc_ref_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .interval(ri_r),
    .restart(restart),
    .expire(expire)
  );

  // strap is caught once the synchroniser has settled, not under reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_cnt_r <= 2'h0;
      init_done_r <= 1'b0;
    end else if (ce && (!init_done_r || init_cnt_r == 2'h0)) begin
      init_cnt_r <= init_cnt_r + 2'h1;
      init_done_r <= init_done_r || (init_cnt_r == RSC_STRAP_WAIT);
    end
  end

  // one edge after the count ends, so the synchroniser output has settled
  assign strap_load = (ce && init_done_r && init_cnt_r == 2'h0) || (ce && sleep_reset);

  // ahb address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else if (ce && hready) begin
      rd_pend_r <= hsel && htrans == RSC_HTRANS_NSEQ && !hwrite;
      wr_pend_r <= hsel && htrans == RSC_HTRANS_NSEQ && hwrite;
      addr_r <= haddr[7:0];
    end else if (ce) begin
      rd_pend_r <= 1'b0;
    end
  end

  assign ctrl_wr = ce && wr_pend_r && addr_r == RSC_OFS_CTRL;
  assign rfsh_wr = ce && wr_pend_r && addr_r == RSC_OFS_RFSH;
  assign new_cke = hwdata[RSC_BIT_CKE];

  // one wait state on reads lets a preceding write land first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= RSC_HRESP_OKAY;
    end else if (ce) begin
      hresp <= RSC_HRESP_OKAY;
      if (hready && hsel && htrans == RSC_HTRANS_NSEQ && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_r) begin
        hreadyout <= 1'b1;
        hrdata <= rd_val;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (addr_r)
      RSC_OFS_CTRL: begin
        rd_val[RSC_BIT_CKE] = cke_r;
        rd_val[RSC_BIT_RUN] = run_r;
        rd_val[RSC_BIT_DIV] = div_r;
      end
      RSC_OFS_RFSH: rd_val[RSC_RI_LSB +: RSC_RI_W] = ri_r;
      RSC_OFS_STAT: begin
        rd_val[RSC_BIT_PEND] = rf_st_r == RF_WAIT;
        rd_val[RSC_BIT_ACT] = rf_st_r == RF_RUN;
        rd_val[RSC_BIT_BLK] = sw_cke_off_r;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // clock enable level bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cke_r <= 1'b0;
    end else if (strap_load) begin
      cke_r <= strap_s;
    end else if (ce && sleep_enter) begin
      cke_r <= 1'b0;
    end else if (ctrl_wr) begin
      cke_r <= new_cke;
    end
  end

  // clock run bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'b0;
    end else if (strap_load) begin
      run_r <= strap_s;
    end else if (ce && sleep_enter) begin
      run_r <= 1'b0;
    end else if (ctrl_wr) begin
      run_r <= hwdata[RSC_BIT_RUN];
    end
  end

  // divide bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= RSC_DIV_RST;
    end else if (ce && sleep_reset) begin
      div_r <= RSC_DIV_RST;
    end else if (ctrl_wr) begin
      div_r <= hwdata[RSC_BIT_DIV];
    end
  end

  // power-down and exit commands on cke edges written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rom_cmd <= '0;
    end else if (ce) begin
      rom_cmd.pd <= ctrl_wr && !strap_load && !sleep_enter && run_r && cke_r && !new_cke;
      rom_cmd.pdx <= ctrl_wr && !strap_load && !sleep_enter && run_r && !cke_r && new_cke;
    end
  end

  // software power-down leaves the rom unable to take auto mrs/read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_cke_off_r <= 1'b0;
    end else if (strap_load) begin
      sw_cke_off_r <= 1'b0;
    end else if (ctrl_wr && !sleep_enter) begin
      sw_cke_off_r <= !new_cke;
    end
  end

  // pins and auto command permissions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rom_clock_pin0 <= 1'b0;
      rom_clock_full_en <= 1'b0;
      rom_clock_enable_pin0 <= 1'b0;
      rom_auto_mrs_read_ok <= 1'b0;
      rom_auto_any_ok <= 1'b0;
    end else if (ce) begin
      // full rate cannot come from a flop; the pad gates hclk with full_en
      rom_clock_pin0 <= (run_r && div_r) ? !rom_clock_pin0 : 1'b0;
      rom_clock_full_en <= run_r && !div_r;
      rom_clock_enable_pin0 <= cke_r;
      rom_auto_mrs_read_ok <= run_r && !sw_cke_off_r;
      rom_auto_any_ok <= run_r;
    end
  end

  // refresh interval register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ri_r <= RSC_RI_RST;
    end else if (rfsh_wr) begin
      ri_r <= hwdata[RSC_RI_LSB +: RSC_RI_W];
    end
  end

  // insertion points; pc card activity is deliberately not a term
  always_comb begin
    ins_ok = 1'b0;
    if (!dram_burst) begin
      if (!sbus.busy) begin
        ins_ok = 1'b1;
      end else if (!sbus.read) begin
        ins_ok = sbus.word_done;
      end else if (sbus.wide32) begin
        ins_ok = rd_cnt_r >= RSC_RD32_CNT;
      end else begin
        ins_ok = rd_cnt_r >= RSC_RD16_CNT;
      end
    end
  end

  always_comb begin
    rf_nxt = rf_st_r;
    unique case (rf_st_r)
      RF_IDLE: if (expire) rf_nxt = RF_WAIT;
      RF_WAIT: if (ins_ok) rf_nxt = RF_RUN;
      RF_RUN: if (refresh_done) rf_nxt = RF_IDLE;
    endcase
  end

  assign restart = rf_st_r == RF_RUN && refresh_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rf_st_r <= RF_IDLE;
    end else if (ce) begin
      rf_st_r <= rf_nxt;
    end
  end

  // read cycles seen while a refresh waits, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_cnt_r <= 2'h0;
    end else if (ce) begin
      if (rf_st_r != RF_WAIT) begin
        rd_cnt_r <= 2'h0;
      end else if (sbus.rd_cycle && rd_cnt_r != 2'h3) begin
        rd_cnt_r <= rd_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refresh_all_banks <= 1'b0;
      static_hold <= 1'b0;
      dram_hold <= 1'b0;
    end else if (ce) begin
      refresh_all_banks <= rf_nxt == RF_RUN;
      static_hold <= rf_nxt == RF_RUN;
      dram_hold <= rf_nxt == RF_RUN;
    end
  end

  a_sleep_cke: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && sleep_enter && !strap_load |=> !cke_r && !rom_cmd.pdx)
    else $error("cke level bit not cleared on sleep");

  a_sleep_run: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && sleep_enter && !strap_load |=> !run_r ##1 !rom_auto_any_ok || !ce)
    else $error("run bit not cleared on sleep");

  a_pd_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_wr && !strap_load && !sleep_enter && run_r && cke_r && !new_cke
    |=> rom_cmd.pd && !cke_r)
    else $error("power-down command missing");

  a_pdx_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_wr && !strap_load && !sleep_enter && run_r && !cke_r && new_cke
    |=> rom_cmd.pdx && cke_r)
    else $error("power-down exit command missing");

  a_mrs_block: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && sw_cke_off_r |=> !rom_auto_mrs_read_ok)
    else $error("auto mrs/read allowed after software power-down");

  a_clk_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !run_r |=> !rom_clock_pin0 && !rom_clock_full_en && !rom_auto_any_ok)
    else $error("rom clock running while run bit clear");

  a_half_rate: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && run_r && div_r |=> rom_clock_pin0 != $past(rom_clock_pin0))
    else $error("rom clock not toggling at half rate");

  a_div_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && sleep_reset |=> div_r)
    else $error("divide bit not set on sleep reset");

  a_burst_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && rf_st_r == RF_WAIT && rf_nxt == RF_RUN |-> !dram_burst ##1 refresh_all_banks)
    else $error("refresh started inside a dram burst");

  a_rd_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && rf_st_r == RF_WAIT && sbus.busy && sbus.read && rf_nxt == RF_RUN
    |-> rd_cnt_r >= (sbus.wide32 ? RSC_RD32_CNT : RSC_RD16_CNT))
    else $error("refresh inserted before read cycles finished");

  a_pend_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && rf_st_r == RF_WAIT && !ins_ok |=> rf_st_r == RF_WAIT && !refresh_all_banks)
    else $error("pending refresh lost");

  a_pccard_free: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && pccard_busy && rf_st_r == RF_WAIT && !dram_burst && !sbus.busy
    |=> rf_st_r == RF_RUN)
    else $error("pc card activity delayed refresh");
endmodule : rsc_ctl

// ==== rsc_pkg.sv ====
// Purpose: shared constants and types for the refresh and sync-rom clock control block
// Assumes: 32-bit ahb-lite register bus, one memory clock
// Notes: bit positions of the rom clock bits follow the control register layout
package rsc_pkg;
  // register byte offsets
  localparam logic [7:0] RSC_OFS_CTRL = 8'h00;
  localparam logic [7:0] RSC_OFS_RFSH = 8'h04;
  localparam logic [7:0] RSC_OFS_STAT = 8'h08;
  // control register fields
  localparam int RSC_BIT_CKE = 16;
  localparam int RSC_BIT_RUN = 17;
  localparam int RSC_BIT_DIV = 18;
  // status register fields
  localparam int RSC_BIT_PEND = 0;
  localparam int RSC_BIT_ACT = 1;
  localparam int RSC_BIT_BLK = 2;
  // refresh interval field, in units of 32 memory clocks
  localparam int RSC_RI_W = 12;
  localparam int RSC_RI_LSB = 0;
  localparam int RSC_RI_SHIFT = 5;
  localparam int RSC_CNT_W = RSC_RI_W + RSC_RI_SHIFT;
  localparam logic [RSC_RI_W-1:0] RSC_RI_RST = 12'h000;
  localparam logic RSC_DIV_RST = 1'b1;
  // read cycles a pending refresh waits for on each bus width
  localparam logic [1:0] RSC_RD16_CNT = 2'h2;
  localparam logic [1:0] RSC_RD32_CNT = 2'h1;
  // cycles after reset release before the strap is trusted
  localparam logic [1:0] RSC_STRAP_WAIT = 2'h3;
  localparam int RSC_BURST_MAX = 8;
  // ahb encodings
  localparam logic [1:0] RSC_HTRANS_NSEQ = 2'h2;
  localparam logic RSC_HRESP_OKAY = 1'b0;

  typedef enum {RF_IDLE, RF_WAIT, RF_RUN} rsc_rf_state_t;

  // static memory engine progress, one cycle pulses except busy, read, wide32
  typedef struct packed {
    logic busy;
    logic word_done;
    logic rd_cycle;
    logic read;
    logic wide32;
  } rsc_sbus_t;

  // one cycle commands to the sync rom
  typedef struct packed {
    logic pd;
    logic pdx;
  } rsc_romcmd_t;
endpackage : rsc_pkg

// ==== rsc_sync3.sv ====
// Purpose: three flop synchroniser for a pin level
// Assumes: input is asynchronous to hclk
// Notes: output moves only when the second and third flops agree
`timescale 1ns/10ps
module rsc_sync3 import rsc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_out <= 1'b0;
    end else if (ce && (s2_r == s3_r)) begin
      level_out <= s3_r;
    end
  end
endmodule : rsc_sync3

// ==== rsc_ref_timer.sv ====
// Purpose: refresh interval counter
// Assumes: interval of zero disables refresh
// Notes: stops after expiry until restarted, so no expiry is lost
`timescale 1ns/10ps
module rsc_ref_timer import rsc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // control
  input wire logic [RSC_RI_W-1:0] interval,
  input wire logic restart,
  // event
  output logic expire
);
  logic [RSC_CNT_W-1:0] cnt_r;
  logic done_r;
  logic [RSC_CNT_W-1:0] limit;

  // interval times 32 clocks
  assign limit = {interval, {RSC_RI_SHIFT{1'b0}}} - {{(RSC_CNT_W-1){1'b0}}, 1'b1};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
      done_r <= 1'b0;
      expire <= 1'b0;
    end else if (ce) begin
      expire <= 1'b0;
      if (restart || interval == '0) begin
        cnt_r <= '0;
        done_r <= 1'b0;
      end else if (!done_r) begin
        if (cnt_r == limit) begin
          done_r <= 1'b1;
          expire <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule : rsc_ref_timer

// ==== rsc_mem_model.sv ====
// Purpose: far-side model of the dram refresh engine and burst traffic
// Assumes: refresh is answered after a prompt or a slow delay
// Notes: a burst restarts only after two idle cycles, so a refresh hold wins
`timescale 1ns/10ps
module rsc_mem_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench control
  input wire logic burst_on,
  input wire logic slow,
  // from controller
  input wire logic refresh_all_banks,
  input wire logic dram_hold,
  // to controller
  output logic dram_burst,
  output logic refresh_done
);
  logic [2:0] bc_r;
  logic [2:0] dc_r;
  logic idle_r;
  // one strobe refreshes a row in every bank at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refresh_done <= 1'b0;
      dc_r <= 3'h0;
    end else if (refresh_done) begin
      refresh_done <= 1'b0;
      dc_r <= 3'h0;
    end else if (refresh_all_banks) begin
      if (dc_r == (slow ? 3'h4 : 3'h0)) refresh_done <= 1'b1;
      else dc_r <= dc_r + 3'h1;
    end
  end
  // bursts of eight words, never started under a hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dram_burst <= 1'b0;
      bc_r <= 3'h0;
      idle_r <= 1'b0;
    end else if (dram_burst) begin
      bc_r <= bc_r + 3'h1;
      idle_r <= 1'b0;
      if (bc_r == 3'h7) dram_burst <= 1'b0;
    end else begin
      idle_r <= 1'b1;
      if (burst_on && idle_r && !dram_hold && !refresh_all_banks) begin
        dram_burst <= 1'b1;
        bc_r <= 3'h0;
      end
    end
  end
endmodule : rsc_mem_model

// ==== refresh_and_sync_rom_clock_ctl_tb_top.sv ====
// Purpose: self-checking bench for the refresh and sync-rom clock control
// Assumes: refresh interval 2, so 64 clocks between refreshes
// Notes: random pc card traffic runs throughout and must never matter
`timescale 1ns/10ps
module refresh_and_sync_rom_clock_ctl_tb_top import rsc_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn, ce, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, ri_v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sleep_enter, sleep_reset, strap, dram_burst, pccard_busy, refresh_done;
  logic refresh_all_banks, static_hold, dram_hold, pin0, full_en, cke_pin;
  logic mrs_ok, any_ok, burst_on, slow, rf_seen, pv_rf, pv_b, a;
  rsc_sbus_t sbus;
  rsc_romcmd_t rom_cmd;
  int err_total = 0;
  int checks_done = 0;
  int pd_n = 0;
  int pdx_n = 0;
  int cnt = 0;
  int gap = 0;
  always #2 hclk = ~hclk;
  rsc_ctl dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_enter(sleep_enter),
    .sleep_reset(sleep_reset), .boot_bank_sync_rom_select(strap), .sbus(sbus),
    .dram_burst(dram_burst), .pccard_busy(pccard_busy), .refresh_done(refresh_done),
    .refresh_all_banks(refresh_all_banks), .static_hold(static_hold),
    .dram_hold(dram_hold), .rom_clock_pin0(pin0), .rom_clock_full_en(full_en),
    .rom_clock_enable_pin0(cke_pin), .rom_cmd(rom_cmd), .rom_auto_mrs_read_ok(mrs_ok),
    .rom_auto_any_ok(any_ok));
  rsc_mem_model mem_u (.hclk(hclk), .hresetn(hresetn), .burst_on(burst_on), .slow(slow),
    .refresh_all_banks(refresh_all_banks), .dram_hold(dram_hold),
    .dram_burst(dram_burst), .refresh_done(refresh_done));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // control word expected from the three rom clock bits
  function automatic logic [31:0] exp_ctrl(input logic ck, input logic rn, input logic dv);
    exp_ctrl = 32'h0;
    exp_ctrl[RSC_BIT_CKE] = ck;
    exp_ctrl[RSC_BIT_RUN] = rn;
    exp_ctrl[RSC_BIT_DIV] = dv;
  endfunction : exp_ctrl
  task finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // master holds each phase until hready is sampled high
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= RSC_HTRANS_NSEQ;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", RSC_HRESP_OKAY, hresp);
  endtask : bus
  task rdc(input string n, input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, ad, 32'h0);
    chk(n, e, rd & m);
  endtask : rdc
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task wait_rise;
    rf_seen = 1'b0;
    for (int i = 0; i < 300 && rf_seen !== 1'b1; i++) @(posedge hclk);
    chk("refresh seen", 32'h1, {31'h0, rf_seen});
  endtask : wait_rise
  // refresh entry watch and command counts
  always @(posedge hclk) begin
    pccard_busy <= 1'($urandom % 2);
    if (rom_cmd.pd === 1'b1) pd_n++;
    if (rom_cmd.pdx === 1'b1) pdx_n++;
    if (refresh_done === 1'b1) cnt = 0;
    else cnt++;
    if (refresh_all_banks === 1'b1 && pv_rf !== 1'b1) begin
      rf_seen = 1'b1;
      gap = cnt;
      chk("no burst", 32'h0, pv_b);
      chk("holds", 32'h3, {static_hold, dram_hold});
    end
    pv_rf = refresh_all_banks;
    pv_b = dram_burst;
  end
  initial begin
    #60000;
    err_total++;
    $display("mismatch watchdog expired");
    finish_test();
  end
  initial begin
    void'($urandom(59389));
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, sleep_enter, sleep_reset} = '0;
    {burst_on, slow, sbus, rf_seen, pv_rf, pv_b} = '0;
    {ce, strap, hsize} = {2'h3, 3'h2};
    cyc(5);
    hresetn <= 1'b1;
    cyc(8);
    rdc("ctrl rst", RSC_OFS_CTRL, exp_ctrl(1'b1, 1'b1, 1'b1), 32'h70000);
    rdc("stat rst", RSC_OFS_STAT, 32'h0, 32'h7);
    a = pin0;
    cyc(1);
    chk("half", {31'h0, ~a}, pin0);
    // clock enable low must freeze the divided clock
    @(posedge hclk) ce <= 1'b0;
    cyc(2);
    a = pin0;
    cyc(3);
    chk("ce freeze", {31'h0, a}, pin0);
    ce <= 1'b1;
    bus(1'b1, RSC_OFS_CTRL, 32'h60000);
    cyc(3);
    chk("pd", 32'h1, pd_n);
    chk("mrs ok", 32'h0, mrs_ok);
    chk("cke pin", 32'h0, cke_pin);
    rdc("blocked", RSC_OFS_STAT, 32'h4, 32'h4);
    bus(1'b1, RSC_OFS_CTRL, 32'h70000);
    cyc(3);
    chk("pdx", 32'h1, pdx_n);
    chk("mrs ok", 32'h1, mrs_ok);
    bus(1'b1, RSC_OFS_CTRL, 32'h30000);
    cyc(3);
    chk("full", 32'h1, {pin0, full_en});
    bus(1'b1, RSC_OFS_CTRL, 32'h10000);
    bus(1'b1, RSC_OFS_CTRL, 32'h00000);
    bus(1'b1, RSC_OFS_CTRL, 32'h50000);
    cyc(3);
    chk("cmds", 32'h11, {pd_n[3:0], pdx_n[3:0]});
    chk("stopped", 32'h0, {any_ok, mrs_ok, pin0, full_en});
    bus(1'b1, RSC_OFS_CTRL, 32'h70000);
    @(posedge hclk) sleep_enter <= 1'b1;
    @(posedge hclk) sleep_enter <= 1'b0;
    rdc("sleep", RSC_OFS_CTRL, exp_ctrl(1'b0, 1'b0, 1'b1), 32'h70000);
    for (int s = 0; s < 2; s++) begin
      strap <= s[0];
      bus(1'b1, RSC_OFS_CTRL, 32'h0);
      cyc(5);
      @(posedge hclk) sleep_reset <= 1'b1;
      @(posedge hclk) sleep_reset <= 1'b0;
      cyc(2);
      rdc("strap", RSC_OFS_CTRL, exp_ctrl(s[0], s[0], 1'b1), 32'h70000);
    end
    bus(1'b1, 8'h0c, $urandom);
    rdc("unmapped", 8'h0c, 32'h0, 32'hffffffff);
    ri_v = {20'h0, 12'($urandom)};
    bus(1'b1, RSC_OFS_RFSH, ri_v);
    rdc("interval", RSC_OFS_RFSH, ri_v, 32'hfff);
    bus(1'b1, RSC_OFS_RFSH, 32'h2);
    wait_rise();
    slow <= 1'b1;
    wait_rise();
    chk("gap", 32'h1, gap >= 64 && gap <= 68);
    burst_on <= 1'b1;
    wait_rise();
    wait_rise();
    chk("burst gap", 32'h1, rf_seen);
    burst_on <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      sbus <= {1'b1, 2'h0, m != 0, m != 1};
      for (int i = 0; i < 60; i++) begin
        bus(1'b0, RSC_OFS_STAT, 32'h0);
        if (rd[RSC_BIT_PEND] === 1'b1) break;
      end
      rf_seen = 1'b0;
      cyc(3);
      chk("held", 32'h0, rf_seen);
      for (int k = 1; k < 3; k++) begin
        @(posedge hclk);
        sbus.word_done <= (m == 0);
        sbus.rd_cycle <= (m != 0);
        @(posedge hclk);
        sbus.word_done <= 1'b0;
        sbus.rd_cycle <= 1'b0;
        cyc(4);
        chk("insert", 32'(k >= (m == 1 ? 2 : 1)), rf_seen);
      end
    end
    sbus <= '0;
    cyc(20);
    finish_test();
  end
endmodule : refresh_and_sync_rom_clock_ctl_tb_top
